// ===== dss_pkg.sv
/*
 * Shared constants and types for the standby and self-test log logic.
 * Assumes a single 250 MHz clock and a task-file front end elsewhere.
 */
package dss_pkg;
	// command opcodes
	localparam logic [7:0] OP_STBY = 8'he2;
	localparam logic [7:0] OP_STBY_OLD = 8'h96;
	localparam logic [7:0] OP_STBY_IMM = 8'he0;
	localparam logic [7:0] OP_STBY_IMM_OLD = 8'h94;
	localparam logic [7:0] OP_SMART = 8'hb0;
	// smart key and subcommands
	localparam logic [7:0] SMART_KEY_MID = 8'h4f;
	localparam logic [7:0] SMART_KEY_HIGH = 8'hc2;
	localparam logic [7:0] SUB_READ_VALUES = 8'hd0;
	localparam logic [7:0] SUB_READ_THRESH = 8'hd1;
	localparam logic [7:0] SUB_SAVE_VALUES = 8'hd3;
	localparam logic [7:0] SUB_ENABLE = 8'hd8;
	localparam logic [7:0] SUB_DISABLE = 8'hd9;
	// completion codes
	localparam logic [7:0] STAT_OK = 8'h50;
	localparam logic [7:0] STAT_FAIL = 8'h51;
	localparam logic [7:0] STAT_BUSY = 8'h80;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam logic [7:0] ERR_UNC = 8'h40;
	localparam logic [7:0] ERR_AMNF = 8'h01;
	// values after reset
	localparam logic [7:0] STAT_RESET = 8'h50;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam logic SMART_ON_RESET = 1'b1;
	// timing
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned SEC_NS = 1000000000;
	localparam int unsigned SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned PD_UNIT_S = 5;
	localparam int unsigned PD_ZERO_MIN = 109;
	localparam int unsigned PD_ZERO_S = PD_ZERO_MIN * 60;
	localparam int unsigned PD_W = 13;
	// self-test log layout
	localparam int unsigned LOG_SLOTS = 21;
	localparam int unsigned DESC_BYTES = 24;
	localparam logic [8:0] DESC_BASE = 9'h002;
	localparam logic [8:0] DESC_END = 9'h1fa;
	localparam logic [8:0] PTR_ADDR = 9'h1fc;
	localparam logic [8:0] SUM_ADDR = 9'h1ff;
	localparam logic [15:0] LOG_REV = 16'h0001;
	localparam logic [4:0] K_NUM = 5'h00;
	localparam logic [4:0] K_STAT = 5'h01;
	localparam logic [4:0] K_HRS = 5'h02;
	localparam logic [4:0] K_CHK = 5'h04;
	localparam logic [4:0] K_LBA = 5'h05;
	localparam logic [4:0] PTR_RESET = 5'h00;

	typedef struct packed {
		logic [7:0] number;
		logic [7:0] status;
		logic [15:0] hours;
		logic [7:0] chkpt;
		logic [31:0] lba;
	} dss_desc_s;

	typedef enum logic [1:0] {S_READY, S_FLUSH, S_SPINDOWN, S_SPINUP} dss_state_e;
endpackage

// ===== dss_log_if.sv
/*
 * Carrier between the command logic and the self-test log store.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ns
interface dss_log_if;
	logic wr_valid;
	dss_pkg::dss_desc_s wr_desc;
	logic [8:0] rd_addr;
	logic [7:0] rd_data;
	logic [4:0] ptr;

	modport ctl(output wr_valid, output wr_desc, output rd_addr,
		input rd_data, input ptr);
	modport store(input wr_valid, input wr_desc, input rd_addr,
		output rd_data, output ptr);
endinterface

// ===== dss_stlog.sv
/*
 * Self-test log sector: 21 descriptors in a ring, pointer and checksum,
 * read one byte at a time with one cycle of latency.
 * Assumes writes and reads come from logic on clk_sys.
 */
`timescale 1ns/1ns
module dss_stlog (
	input wire logic clk_sys,
	input wire logic reset,
	dss_log_if.store lg
);
	typedef struct packed {
		dss_pkg::dss_desc_s [dss_pkg::LOG_SLOTS-1:0] desc;
		logic [4:0] ptr;
		logic [7:0] rd_data;
	} dss_log_s;

	dss_log_s cur_ff, nxt_cur;

	// eight-bit sum of the nine meaningful bytes of one descriptor
	function automatic logic [7:0] desc_sum(input dss_pkg::dss_desc_s d);
		desc_sum = d.number + d.status + d.hours[7:0] + d.hours[15:8]
			+ d.chkpt + d.lba[7:0] + d.lba[15:8] + d.lba[23:16]
			+ d.lba[31:24];
	endfunction

	logic [7:0] sum;
	logic [8:0] d;
	logic [4:0] n;
	logic [4:0] k;
	dss_pkg::dss_desc_s sel;

	always_comb begin
		nxt_cur = cur_ff;
		// checksum makes the whole sector add to zero
		sum = dss_pkg::LOG_REV[7:0] + dss_pkg::LOG_REV[15:8]
			+ 8'(cur_ff.ptr);
		for (int i = 0; i < dss_pkg::LOG_SLOTS; i++) begin
			sum = sum + desc_sum(cur_ff.desc[i]);
		end
		// ring write: slot after the latest, wrapping to 0
		if (lg.wr_valid) begin
			nxt_cur.desc[cur_ff.ptr == 5'(dss_pkg::LOG_SLOTS) ? 5'h00
				: cur_ff.ptr] = lg.wr_desc;
			nxt_cur.ptr = cur_ff.ptr == 5'(dss_pkg::LOG_SLOTS) ? 5'h01
				: cur_ff.ptr + 5'h01;
		end
		// byte map of the sector, fields little-endian
		d = lg.rd_addr - dss_pkg::DESC_BASE;
		n = 5'(d / 9'(dss_pkg::DESC_BYTES));
		k = 5'(d % 9'(dss_pkg::DESC_BYTES));
		sel = cur_ff.desc[n < 5'(dss_pkg::LOG_SLOTS) ? n : 5'h00];
		nxt_cur.rd_data = 8'h00;
		if (lg.rd_addr < dss_pkg::DESC_BASE) begin
			nxt_cur.rd_data = lg.rd_addr[0] ? dss_pkg::LOG_REV[15:8]
				: dss_pkg::LOG_REV[7:0];
		end else if (lg.rd_addr < dss_pkg::DESC_END) begin
			case (k)
				dss_pkg::K_NUM: nxt_cur.rd_data = sel.number;
				dss_pkg::K_STAT: nxt_cur.rd_data = sel.status;
				dss_pkg::K_HRS: nxt_cur.rd_data = sel.hours[7:0];
				dss_pkg::K_HRS + 5'h01: nxt_cur.rd_data = sel.hours[15:8];
				dss_pkg::K_CHK: nxt_cur.rd_data = sel.chkpt;
				dss_pkg::K_LBA: nxt_cur.rd_data = sel.lba[7:0];
				dss_pkg::K_LBA + 5'h01: nxt_cur.rd_data = sel.lba[15:8];
				dss_pkg::K_LBA + 5'h02: nxt_cur.rd_data = sel.lba[23:16];
				dss_pkg::K_LBA + 5'h03: nxt_cur.rd_data = sel.lba[31:24];
				default: nxt_cur.rd_data = 8'h00; // vendor bytes
			endcase
		end else if (lg.rd_addr == dss_pkg::PTR_ADDR) begin
			nxt_cur.rd_data = 8'(cur_ff.ptr);
		end else if (lg.rd_addr == dss_pkg::SUM_ADDR) begin
			nxt_cur.rd_data = 8'h00 - sum;
		end
		if (reset) begin
			nxt_cur = '0;
			nxt_cur.ptr = dss_pkg::PTR_RESET;
		end
	end

	always_ff @(posedge clk_sys) begin
		cur_ff <= nxt_cur;
	end

	assign lg.rd_data = cur_ff.rd_data;
	assign lg.ptr = cur_ff.ptr;
endmodule

// ===== dss_top.sv
/*
 * Standby power commands with the auto power-down timer, smart
 * command checks with their completion codes, and the self-test log.
 * Assumes the task-file front end, spindle, cache and self-test
 * engines are logic on clk_sys, so their signals are not synchronised.
 */
`timescale 1ns/1ns
module dss_top #(
	parameter int unsigned SEC_CYCLES = dss_pkg::SEC_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [7:0] cmd_features,
	input wire logic [7:0] cmd_sector_count,
	input wire logic [7:0] cmd_lba_mid,
	input wire logic [7:0] cmd_lba_high,
	input wire logic host_access,
	input wire logic status_read,
	output logic [7:0] command_completion_state,
	output logic [7:0] command_error_flags,
	output logic intrq,
	output logic fwd_valid,
	output logic [7:0] fwd_opcode,
	output logic flush_req,
	input wire logic flush_done,
	output logic spin_down_req,
	output logic spin_up_req,
	input wire logic spindle_stopped,
	input wire logic spindle_at_speed,
	output logic standby_mode,
	input wire logic attr_read_fail,
	input wire logic attr_write_fail,
	input wire logic st_valid,
	input wire logic [7:0] st_number,
	input wire logic [7:0] st_status,
	input wire logic [15:0] st_hours,
	input wire logic [7:0] st_chkpt,
	input wire logic [31:0] st_lba,
	input wire logic [8:0] log_rd_addr,
	output logic [7:0] log_rd_data,
	output logic [4:0] log_ptr
);
	typedef struct packed {
		dss_pkg::dss_state_e st;
		logic standby;
		logic auto_pd;
		logic pd_en;
		logic [dss_pkg::PD_W-1:0] pd_reload;
		logic [dss_pkg::PD_W-1:0] pd_cnt;
		logic [31:0] sec_cnt;
		logic smart_on;
		logic [7:0] status;
		logic [7:0] error;
		logic intrq;
		logic fwd_valid;
		logic [7:0] fwd_op;
		logic flush_req;
		logic spin_down;
		logic spin_up;
	} dss_ctl_s;

	dss_ctl_s cur_ff, nxt_cur;
	dss_log_if lg();

	// interval in seconds from the sector count
	function automatic logic [dss_pkg::PD_W-1:0] pd_secs(
		input logic [7:0] sc);
		if (sc == 8'h00) begin
			pd_secs = dss_pkg::PD_W'(dss_pkg::PD_ZERO_S);
		end else begin
			pd_secs = dss_pkg::PD_W'(sc) *
				dss_pkg::PD_W'(dss_pkg::PD_UNIT_S);
		end
	endfunction

	// smart checks in priority order, {status, error}
	function automatic logic [15:0] smart_result(
		input logic [7:0] feat,
		input logic [7:0] mid,
		input logic [7:0] high,
		input logic on,
		input logic rd_fail,
		input logic wr_fail);
		logic known;
		known = feat == dss_pkg::SUB_READ_VALUES ||
			feat == dss_pkg::SUB_READ_THRESH ||
			feat == dss_pkg::SUB_SAVE_VALUES ||
			feat == dss_pkg::SUB_ENABLE ||
			feat == dss_pkg::SUB_DISABLE;
		smart_result = {dss_pkg::STAT_OK, dss_pkg::ERR_NONE};
		if (mid != dss_pkg::SMART_KEY_MID ||
			high != dss_pkg::SMART_KEY_HIGH) begin
			smart_result = {dss_pkg::STAT_FAIL, dss_pkg::ERR_ABORT};
		end else if (!known) begin
			smart_result = {dss_pkg::STAT_FAIL, dss_pkg::ERR_ABORT};
		end else if (!on && feat != dss_pkg::SUB_ENABLE) begin
			smart_result = {dss_pkg::STAT_FAIL, dss_pkg::ERR_ABORT};
		end else if (rd_fail && (feat == dss_pkg::SUB_READ_VALUES ||
			feat == dss_pkg::SUB_READ_THRESH)) begin
			smart_result = {dss_pkg::STAT_FAIL, dss_pkg::ERR_UNC};
		end else if (wr_fail && feat == dss_pkg::SUB_SAVE_VALUES) begin
			smart_result = {dss_pkg::STAT_FAIL, dss_pkg::ERR_AMNF};
		end
	endfunction

	logic is_stby;
	logic is_imm;
	logic sec_tick;
	logic [15:0] sres;

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.fwd_valid = 1'b0;
		is_stby = cmd_opcode == dss_pkg::OP_STBY ||
			cmd_opcode == dss_pkg::OP_STBY_OLD;
		is_imm = cmd_opcode == dss_pkg::OP_STBY_IMM ||
			cmd_opcode == dss_pkg::OP_STBY_IMM_OLD;
		sres = smart_result(cmd_features, cmd_lba_mid, cmd_lba_high,
			cur_ff.smart_on, attr_read_fail, attr_write_fail);
		sec_tick = cur_ff.sec_cnt == SEC_CYCLES - 1;

		// interrupt held until status is read; a new one wins
		if (status_read) begin
			nxt_cur.intrq = 1'b0;
		end

		// seconds divider and interval countdown, idle mode only
		if (cur_ff.pd_en && !cur_ff.standby &&
			cur_ff.st == dss_pkg::S_READY) begin
			nxt_cur.sec_cnt = sec_tick ? 32'h0 : cur_ff.sec_cnt + 32'h1;
			if (sec_tick) begin
				nxt_cur.pd_cnt = cur_ff.pd_cnt - 1'b1;
			end
		end
		if (host_access || cmd_valid) begin
			nxt_cur.sec_cnt = 32'h0;
			nxt_cur.pd_cnt = cur_ff.pd_reload;
		end

		case (cur_ff.st)
			dss_pkg::S_READY: begin
				if (cmd_valid && (is_stby || is_imm)) begin
					if (is_stby) begin
						nxt_cur.pd_reload = pd_secs(cmd_sector_count);
						nxt_cur.pd_en = 1'b1;
					end // immediate form keeps the interval
					nxt_cur.auto_pd = 1'b0;
					nxt_cur.status = dss_pkg::STAT_BUSY;
					nxt_cur.flush_req = 1'b1;
					nxt_cur.st = dss_pkg::S_FLUSH;
				end else if (cmd_valid &&
					cmd_opcode == dss_pkg::OP_SMART) begin
					nxt_cur.status = sres[15:8];
					nxt_cur.error = sres[7:0];
					nxt_cur.intrq = 1'b1;
					if (sres[15:8] == dss_pkg::STAT_OK &&
						cmd_features == dss_pkg::SUB_ENABLE) begin
						nxt_cur.smart_on = 1'b1;
					end
					if (sres[15:8] == dss_pkg::STAT_OK &&
						cmd_features == dss_pkg::SUB_DISABLE) begin
						nxt_cur.smart_on = 1'b0;
					end
				end else if (cmd_valid && cur_ff.standby) begin
					// park the command until the spindle is up
					nxt_cur.fwd_op = cmd_opcode;
					nxt_cur.status = dss_pkg::STAT_BUSY;
					nxt_cur.spin_down = 1'b0;
					nxt_cur.spin_up = 1'b1;
					nxt_cur.st = dss_pkg::S_SPINUP;
				end else if (cmd_valid) begin
					nxt_cur.fwd_op = cmd_opcode;
					nxt_cur.fwd_valid = 1'b1;
				end else if (cur_ff.pd_en && !cur_ff.standby && sec_tick &&
					cur_ff.pd_cnt <= 1 && !host_access) begin
					// interval ran out with no access
					nxt_cur.auto_pd = 1'b1;
					nxt_cur.flush_req = 1'b1;
					nxt_cur.st = dss_pkg::S_FLUSH;
				end
			end
			dss_pkg::S_FLUSH: begin
				// cached writes must land before the interrupt
				if (flush_done) begin
					nxt_cur.flush_req = 1'b0;
					nxt_cur.spin_up = 1'b0;
					nxt_cur.spin_down = 1'b1;
					nxt_cur.st = dss_pkg::S_SPINDOWN;
				end
			end
			dss_pkg::S_SPINDOWN: begin
				// a stopped spindle completes at once
				if (spindle_stopped) begin
					nxt_cur.standby = 1'b1;
					nxt_cur.st = dss_pkg::S_READY;
					if (!cur_ff.auto_pd) begin
						nxt_cur.status = dss_pkg::STAT_OK;
						nxt_cur.error = dss_pkg::ERR_NONE;
						nxt_cur.intrq = 1'b1;
					end
				end
			end
			dss_pkg::S_SPINUP: begin
				if (spindle_at_speed) begin
					nxt_cur.spin_up = 1'b0;
					nxt_cur.standby = 1'b0;
					nxt_cur.status = dss_pkg::STAT_OK;
					nxt_cur.fwd_valid = 1'b1;
					nxt_cur.sec_cnt = 32'h0;
					nxt_cur.pd_cnt = cur_ff.pd_reload;
					nxt_cur.st = dss_pkg::S_READY;
				end
			end
			default: begin
				nxt_cur.st = dss_pkg::S_READY;
			end
		endcase

		if (reset) begin
			nxt_cur = '0;
			nxt_cur.st = dss_pkg::S_READY;
			nxt_cur.smart_on = dss_pkg::SMART_ON_RESET;
			nxt_cur.status = dss_pkg::STAT_RESET;
			nxt_cur.error = dss_pkg::ERR_RESET;
		end
	end

	always_ff @(posedge clk_sys) begin
		cur_ff <= nxt_cur;
	end

	// self-test results go straight into the ring
	assign lg.wr_valid = st_valid;
	assign lg.wr_desc = '{number: st_number, status: st_status,
		hours: st_hours, chkpt: st_chkpt, lba: st_lba};
	assign lg.rd_addr = log_rd_addr;

	dss_stlog u_log (
		.clk_sys(clk_sys),
		.reset(reset),
		.lg(lg.store)
	);

	// outputs straight from the state flops
	assign command_completion_state = cur_ff.status;
	assign command_error_flags = cur_ff.error;
	assign intrq = cur_ff.intrq;
	assign fwd_valid = cur_ff.fwd_valid;
	assign fwd_opcode = cur_ff.fwd_op;
	assign flush_req = cur_ff.flush_req;
	assign spin_down_req = cur_ff.spin_down;
	assign spin_up_req = cur_ff.spin_up;
	assign standby_mode = cur_ff.standby;
	assign log_rd_data = lg.rd_data;
	assign log_ptr = lg.ptr;
endmodule

// ===== dss_top_assertions.sv
/* Checker on the dss_top ports: smart codes, standby steps, log pointer.
 * Assumes the cache and spindle answer within a few dozen cycles. */
`timescale 1ns/1ns
module dss_top_assertions (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [7:0] cmd_features,
	input wire logic [7:0] cmd_lba_mid,
	input wire logic [7:0] cmd_lba_high,
	input wire logic status_read,
	input wire logic [7:0] command_completion_state,
	input wire logic [7:0] command_error_flags,
	input wire logic intrq,
	input wire logic fwd_valid,
	input wire logic flush_req,
	input wire logic spin_up_req,
	input wire logic spindle_stopped,
	input wire logic standby_mode,
	input wire logic st_valid,
	input wire logic [4:0] log_ptr
);
	logic rdy, is_stby, is_sm, key_ok, sub_ok;
	// decode of the command on the port, busy status refuses it
	assign rdy = command_completion_state != dss_pkg::STAT_BUSY;
	assign is_stby = cmd_opcode inside {8'he2, 8'h96, 8'he0, 8'h94};
	assign is_sm = cmd_opcode == dss_pkg::OP_SMART;
	assign key_ok = cmd_lba_mid == 8'h4f && cmd_lba_high == 8'hc2;
	assign sub_ok = cmd_features inside {8'hd0, 8'hd1, 8'hd3, 8'hd8, 8'hd9};

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	// taken commands and the abort answer
	sequence stby_s;
		cmd_valid && rdy && is_stby;
	endsequence
	sequence wake_s;
		cmd_valid && rdy && standby_mode && !is_stby && !is_sm;
	endsequence
	sequence abort_s;
		command_completion_state == 8'h51 && command_error_flags == 8'h04
			&& intrq;
	endsequence

	stby_busy_a: assert property (stby_s |=> !rdy)
		else $error("standby not busy");
	stby_end_a: assert property (stby_s |-> ##[2:64] intrq)
		else $error("standby never ends");
	irq_late_a: assert property ($rose(intrq) |-> !flush_req)
		else $error("irq before flush");
	stby_code_a: assert property ($rose(intrq) && $rose(standby_mode) |->
		command_completion_state == 8'h50 && command_error_flags == 8'h00)
		else $error("standby code");
	stop_skip_a: assert property (stby_s ##0 spindle_stopped |=>
		!spin_up_req [*8]) else $error("stopped spindle restarted");
	irq_hold_a: assert property (intrq && !status_read |=> intrq)
		else $error("irq dropped");
	key_abort_a: assert property (cmd_valid && rdy && is_sm && !key_ok
		|=> abort_s) else $error("bad key accepted");
	sub_abort_a: assert property (cmd_valid && rdy && is_sm && key_ok
		&& !sub_ok |=> abort_s) else $error("bad subcommand accepted");
	wake_busy_a: assert property (wake_s |=> !rdy && spin_up_req)
		else $error("wake not busy");
	wake_fwd_a: assert property (wake_s |-> ##[2:64] fwd_valid)
		else $error("wake never runs");
	ptr_step_a: assert property (st_valid && log_ptr < 5'd21 |=>
		log_ptr == $past(log_ptr) + 5'd1) else $error("pointer step");
	ptr_wrap_a: assert property (st_valid && log_ptr == 5'd21 |=>
		log_ptr == 5'd1) else $error("pointer wrap");
	ptr_hold_a: assert property (!st_valid |=> $stable(log_ptr))
		else $error("pointer moved");
	ptr_range_a: assert property (log_ptr <= 5'd21)
		else $error("pointer range");
endmodule

bind dss_top dss_top_assertions u_chk (.clk_sys, .reset, .cmd_valid,
	.cmd_opcode, .cmd_features, .cmd_lba_mid, .cmd_lba_high, .status_read,
	.command_completion_state, .command_error_flags, .intrq, .fwd_valid,
	.flush_req, .spin_up_req, .spindle_stopped, .standby_mode, .st_valid,
	.log_ptr);

// ===== dss_mech.sv
/* Cache and spindle stand-in: answers flush, spin-down and spin-up.
 * Assumes requests are levels held until answered, on clk_sys. */
`timescale 1ns/1ns
module dss_mech (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic slow,
	input wire logic flush_req,
	input wire logic spin_down_req,
	input wire logic spin_up_req,
	output logic flush_done,
	output logic spindle_stopped,
	output logic spindle_at_speed
);
	logic [2:0] wait_ff;
	logic pend;
	// one shared delay: cache and spindle never move together
	assign pend = (flush_req && !flush_done)
		|| (spin_up_req && !spindle_at_speed)
		|| (spin_down_req && !spindle_stopped);

	// answer after 2 or 6 cycles, speed drops at once on spin-down
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wait_ff <= 3'h0;
			flush_done <= 1'b0;
			{spindle_stopped, spindle_at_speed} <= 2'b01;
		end else begin
			flush_done <= 1'b0;
			if (spin_down_req && !spin_up_req)
				spindle_at_speed <= 1'b0;
			if (!pend)
				wait_ff <= 3'h0;
			else if (wait_ff != (slow ? 3'h5 : 3'h1))
				wait_ff <= wait_ff + 3'h1;
			else begin
				wait_ff <= 3'h0;
				if (flush_req && !flush_done)
					flush_done <= 1'b1;
				else if (spin_up_req && !spindle_at_speed)
					{spindle_stopped, spindle_at_speed} <= 2'b01;
				else
					{spindle_stopped, spindle_at_speed} <= 2'b10;
			end
		end
	end
endmodule

// ===== tb_top.sv
/* Bench for dss_top: smart codes, standby, power-down timer, log.
 * Assumes dss_mech stands in for cache and spindle. */
`timescale 1ns/1ns
module tb_top;
	localparam int unsigned SC = 10;
	localparam logic [39:0] OPS = 40'he2_e0_96_94_e2;
	localparam logic [39:0] SCS = 40'h00_30_01_30_01;
	logic clk_sys, reset, cmd_valid, host_access, status_read, slow;
	logic flush_done, spindle_stopped, spindle_at_speed, intrq, fwd_valid;
	logic attr_read_fail, attr_write_fail, st_valid, flush_req;
	logic spin_down_req, spin_up_req, standby_mode;
	logic [7:0] cmd_opcode, cmd_features, cmd_sector_count, cmd_lba_mid;
	logic [7:0] cmd_lba_high, command_completion_state, command_error_flags;
	logic [7:0] fwd_opcode, log_rd_data, st_number, st_status, st_chkpt;
	logic [15:0] st_hours;
	logic [31:0] st_lba, seed, t;
	logic [8:0] log_rd_addr;
	logic [4:0] log_ptr, ptr;
	logic [7:0] img [0:511];
	int n_fail, n_checks;

	dss_top #(.SEC_CYCLES(SC)) u_dss_top (.clk_sys, .reset, .cmd_valid,
		.cmd_opcode, .cmd_features, .cmd_sector_count, .cmd_lba_mid,
		.cmd_lba_high, .host_access, .status_read, .command_completion_state,
		.command_error_flags, .intrq, .fwd_valid, .fwd_opcode, .flush_req,
		.flush_done, .spin_down_req, .spin_up_req, .spindle_stopped,
		.spindle_at_speed, .standby_mode, .attr_read_fail, .attr_write_fail,
		.st_valid, .st_number, .st_status, .st_hours, .st_chkpt, .st_lba,
		.log_rd_addr, .log_rd_data, .log_ptr);
	dss_mech u_dss_mech (.clk_sys, .reset, .slow, .flush_req, .spin_down_req,
		.spin_up_req, .flush_done, .spindle_stopped, .spindle_at_speed);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// expected idle interval in cycles from the sector count
	function automatic int pd_cycles(logic [7:0] sc);
		return (sc == 8'h00 ? 109 * 60 : int'(sc) * 5) * SC;
	endfunction

	task automatic close_out();
		if (n_fail == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one command write; returns after the taking edge has landed
	task automatic cmd(logic [7:0] o, f, s, m, h);
		@(negedge clk_sys);
		{cmd_opcode, cmd_features, cmd_sector_count} = {o, f, s};
		{cmd_lba_mid, cmd_lba_high} = {m, h};
		// drive select lives outside these ports, host keeps it set
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
	endtask

	task automatic ack();
		@(negedge clk_sys);
		status_read = 1'b1;
		@(negedge clk_sys);
		status_read = 1'b0;
	endtask

	task automatic sm(logic [7:0] f, m, h, logic [1:0] fl, logic [15:0] se);
		{attr_read_fail, attr_write_fail} = fl;
		cmd(8'hb0, f, 8'h00, m, h);
		chk("smart code", {command_completion_state, command_error_flags},
			se);
		chk("smart irq", intrq, 1'b1);
		ack();
	endtask

	task automatic wait_fwd();
		for (int i = 0; i < 100 && fwd_valid !== 1'b1; i++)
			@(negedge clk_sys);
		chk("forward", {fwd_valid, fwd_opcode}, 9'h120);
	endtask

	// idle countdown n cycles; hit pokes the host 15 cycles short of expiry to restart it
	task automatic tmr(int n, bit hit);
		slow = 1'b0;
		repeat (n - 15) @(negedge clk_sys);
		chk("early", standby_mode, 1'b0);
		if (hit) begin
			host_access = 1'b1;
			@(negedge clk_sys);
			host_access = 1'b0;
			repeat (n - 15) @(negedge clk_sys);
			chk("restart", standby_mode, 1'b0);
		end
		for (int i = 0; i < 40 && standby_mode !== 1'b1; i++)
			@(negedge clk_sys);
		chk("expiry", {standby_mode, intrq}, 2'b10);
	endtask

	// one random descriptor, mirrored into the expected sector image
	task automatic st_put();
		int b;
		b = (ptr == 5'd21 ? 0 : int'(ptr)) * 24 + 2;
		@(negedge clk_sys);
		{st_number, st_status, st_hours} = rnd();
		t = rnd();
		st_chkpt = t[7:0];
		st_lba = rnd();
		{img[b], img[b + 1], img[b + 2], img[b + 3]} =
			{st_number, st_status, st_hours[7:0], st_hours[15:8]};
		img[b + 4] = st_chkpt;
		for (int k = 0; k < 4; k++)
			img[b + 5 + k] = st_lba[8 * k +: 8];
		ptr = ptr == 5'd21 ? 5'd1 : ptr + 5'd1;
		st_valid = 1'b1;
		@(negedge clk_sys);
		st_valid = 1'b0;
		chk("log pointer", log_ptr, ptr);
	endtask

	task automatic rd_all();
		logic [7:0] s;
		s = 8'h00;
		img[508] = {3'h0, ptr};
		for (int a = 0; a < 511; a++)
			s = s - img[a];
		img[511] = s;
		for (int a = 0; a < 512; a++) begin
			@(negedge clk_sys);
			log_rd_addr = a[8:0];
			@(negedge clk_sys);
			chk("log byte", log_rd_data, img[a]);
		end
	endtask

	// free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// hang guard, well above the expected run length
	initial begin
		repeat (90000) @(negedge clk_sys);
		n_fail++;
		close_out();
	end

	// main sequence
	initial begin
		{cmd_valid, host_access, status_read, attr_read_fail} = 4'h0;
		{attr_write_fail, st_valid, slow, reset} = 4'h1;
		{cmd_opcode, cmd_features, cmd_sector_count, cmd_lba_mid} = 32'h0;
		{cmd_lba_high, st_number, st_status, st_chkpt} = 32'h0;
		{st_hours, st_lba, log_rd_addr} = 57'h0;
		{n_fail, n_checks, seed, ptr} = {64'h0, 32'h0000001c, 5'h00};
		foreach (img[a])
			img[a] = 8'h00;
		{img[1], img[0]} = dss_pkg::LOG_REV;
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		chk("empty log", log_ptr, 5'h00);
		sm(8'hd0, 8'h4f, 8'hc2, 2'b00, 16'h5000);
		sm(8'hd0, 8'h4e, 8'hc2, 2'b00, 16'h5104);
		sm(8'hd8, 8'h4f, 8'h2c, 2'b00, 16'h5104);
		for (int i = 0; i < 6; i++) begin
			t = rnd();
			if (t[7:0] inside {8'hd0, 8'hd1, 8'hd3, 8'hd8, 8'hd9})
				t[7:0] = 8'hd2;
			sm(t[7:0], 8'h4f, 8'hc2, 2'b00, 16'h5104);
		end
		sm(8'hd0, 8'h4f, 8'hc2, 2'b10, 16'h5140);
		sm(8'hd1, 8'h4f, 8'hc2, 2'b10, 16'h5140);
		sm(8'hd3, 8'h4f, 8'hc2, 2'b01, 16'h5101);
		sm(8'hd9, 8'h4f, 8'hc2, 2'b00, 16'h5000);
		sm(8'hd3, 8'h4f, 8'hc2, 2'b01, 16'h5104);
		sm(8'hd9, 8'h4f, 8'hc2, 2'b00, 16'h5104);
		sm(8'hd8, 8'h4f, 8'hc2, 2'b00, 16'h5000);
		sm(8'hd1, 8'h4f, 8'hc2, 2'b00, 16'h5000);
		for (int i = 0; i < 21; i++)
			st_put();
		rd_all();
		for (int i = 0; i < 9; i++)
			st_put();
		rd_all();
		cmd(8'h20, 8'h00, 8'h00, 8'h00, 8'h00);
		chk("idle forward", {fwd_valid, fwd_opcode}, 9'h120);
		for (int i = 0; i < 5; i++) begin
			t = rnd();
			slow = t[0];
			cmd(OPS[8 * i +: 8], 8'h00, SCS[8 * i +: 8], 8'h00, 8'h00);
			chk("stby busy", {command_completion_state, flush_req},
				9'h101);
			for (int k = 0; k < 100 && intrq !== 1'b1; k++)
				@(negedge clk_sys);
			chk("stby done", {command_completion_state, command_error_flags,
				intrq, standby_mode, spin_up_req, spin_down_req},
				20'h5000d);
			ack();
			repeat (60) @(negedge clk_sys);
			cmd(8'h20, 8'h00, 8'h00, 8'h00, 8'h00);
			chk("wake", {command_completion_state, spin_up_req,
				spin_down_req}, 10'h202);
			wait_fwd();
			if (i == 4)
				tmr(pd_cycles(SCS[8 * i +: 8]), 1'b0);
			else
				tmr(pd_cycles(8'h01), 1'b1);
		end
		close_out();
	end
endmodule
